// File: sim/dcc_analog_model.sv
module dcc_analog_model
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire dcc_analog_cfg_t cfg,
    input wire logic level,
    output logic out
);
    // ==========
    // Comparator macro
    logic [1:0] cnt = 2'h0;
    initial out = 1'b0;
    always @(posedge clk_sys) begin
        if (!cfg.enable) begin
            out <= ~out; // Powered down: output is noise
        end else if (level == out) begin
            cnt <= cfg.speed_mode; // Slower modes answer later
        end else if (cnt == 2'h0) begin
            out <= level; // High when plus input is above minus
        end else begin
            cnt <= cnt - 2'h1;
        end
    end
endmodule : dcc_analog_model

// File: sim/dcc_top_assertions.sv
module dcc_top_assertions
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire dcc_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic [1:0] cmp_analog_out,
    input wire dcc_analog_cfg_t [1:0] cmp_cfg,
    input wire logic [1:0] cmp_raw_pin,
    input wire logic [1:0] cmp_sync_pin,
    input wire logic [1:0] cmp_irq
);
    // ==========
    // Checks
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    wire logic rd_q = sfr_req.rd && ce;
    wire logic wr_q = sfr_req.wr && ce;
    wire logic [7:0] ad = sfr_req.addr;
    wire logic [7:0] wd = sfr_req.wdata;
    wire logic [1:0] en = {cmp_cfg[1].enable, cmp_cfg[0].enable};

    a_raw_gate: assert property (cmp_raw_pin == (cmp_analog_out & en))
        else $error("raw pin not gated");
    a_sync_off: assert property (!en[0] [*3] |-> !cmp_sync_pin[0])
        else $error("sync pin high while off");
    a_sync_track: assert property ((en[0] && ce && $stable(cmp_analog_out[0])) [*5]
        |-> cmp_sync_pin[0] == cmp_analog_out[0]) else $error("sync pin lags");
    a_read_idle: assert property (!$past(rd_q) |-> sfr_rdata == 8'h00)
        else $error("read data without read");
    a_read_unmapped: assert property ($past(rd_q && (ad < 8'h9a || ad > 8'h9f))
        |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_unused_zero: assert property ($past(rd_q && ad >= 8'h9c && ad <= 8'h9f)
        |-> (sfr_rdata & 8'hcc) == 8'h00) else $error("unused bits set");
    a_enable_write: assert property (wr_q && ad == DCC_ADDR_CMP0_CONTROL
        |=> cmp_cfg[0].enable == $past(wd[7])) else $error("enable not written");
    a_hyst_write: assert property (wr_q && ad == DCC_ADDR_CMP1_CONTROL
        |=> {cmp_cfg[1].pos_hyst, cmp_cfg[1].neg_hyst} == $past(wd[3:0]))
        else $error("hysteresis not written");
    a_speed_write: assert property (wr_q && ad == DCC_ADDR_CMP0_MODE_SELECT
        |=> cmp_cfg[0].speed_mode == $past(wd[1:0])) else $error("speed not written");
    a_source_write: assert property (wr_q && ad == DCC_ADDR_CMP1_INPUT_SELECT
        |=> {cmp_cfg[1].neg_source, cmp_cfg[1].pos_source} == {$past(wd[5:4]), $past(wd[1:0])})
        else $error("source not written");
    a_reset_mode: assert property ($fell(srst) |-> cmp_cfg[0].speed_mode == DCC_RST_SPEED_MODE
        && !en[0]) else $error("bad reset config");
    c_irq: cover property ($rose(cmp_irq[0]));
    c_read: cover property (rd_q ##1 sfr_rdata != 8'h00);
    c_raw: cover property ($rose(cmp_raw_pin[1]));
endmodule : dcc_top_assertions

bind dcc_top dcc_top_assertions dcc_top_assertions_inst (.clk_sys(clk_sys), .srst(srst),
    .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cmp_analog_out(cmp_analog_out),
    .cmp_cfg(cmp_cfg), .cmp_raw_pin(cmp_raw_pin), .cmp_sync_pin(cmp_sync_pin),
    .cmp_irq(cmp_irq));

// File: sim/dcc_top_tb.sv
module dcc_top_tb
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Bench
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    dcc_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic [1:0] level = 2'h0;
    logic [1:0] cmp_analog_out;
    logic [1:0] cmp_raw_pin;
    logic [1:0] cmp_sync_pin;
    logic [1:0] cmp_irq;
    dcc_analog_cfg_t [1:0] cmp_cfg;
    int errors = 0;
    int checks = 0;
    logic [7:0] a;
    logic [7:0] d;
    initial forever #25 clk_sys = ~clk_sys;
    dcc_top dcc_top_inst (.clk_sys(clk_sys), .srst(srst), .ce(ce), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .cmp_analog_out(cmp_analog_out), .cmp_cfg(cmp_cfg),
        .cmp_raw_pin(cmp_raw_pin), .cmp_sync_pin(cmp_sync_pin), .cmp_irq(cmp_irq));
    for (genvar g = 0; g < 2; g++) begin : g_an
        dcc_analog_model dcc_analog_model_inst (.clk_sys(clk_sys), .cfg(cmp_cfg[g]),
            .level(level[g]), .out(cmp_analog_out[g]));
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk_sys);
        sfr_req <= '{1'b1, 1'b0, ad, v};
        @(posedge clk_sys);
        sfr_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [7:0] e, input string n);
        @(posedge clk_sys);
        sfr_req <= '{1'b0, 1'b1, ad, 8'h00};
        @(posedge clk_sys);
        sfr_req <= '0;
        #1 chk(n, e, sfr_rdata);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    function automatic logic [7:0] ctl(input logic r, input logic rf, input logic ff);
        return {1'b1, r, rf, ff, d[3:0]};
    endfunction : ctl
    task automatic pins(input logic [7:0] e, input int c);
        // Look just after the edge so the registered pins have settled
        #1 chk("pins", e, {5'h0, cmp_raw_pin[c], cmp_sync_pin[c], cmp_irq[c]});
    endtask : pins
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(89467));
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            a = 8'h99 + 8'(i);
            rd(a, (a == 8'h9c || a == 8'h9d) ? 8'h02 : 8'h00, "reset");
        end
        for (int i = 0; i < 16; i++) begin
            a = 8'h9c + 8'(i % 4);
            d = 8'($urandom);
            wr(a, d);
            rd(a, d & 8'h33, "select");
        end
        for (int c = 0; c < 2; c++) begin
            a = 8'h9b - 8'(c);
            d = 8'($urandom);
            wr(a + 8'h02, 8'h20);
            wr(a, {4'h8, d[3:0]});
            idle(8);
            wr(a, {4'h8, d[3:0]});
            rd(a, ctl(1'b0, 1'b0, 1'b0), "control");
            level[c] <= 1'b1;
            idle(10);
            rd(a, ctl(1'b1, 1'b1, 1'b0), "rise");
            pins(8'h07, c);
            level[c] <= 1'b0;
            idle(10);
            rd(a, ctl(1'b0, 1'b1, 1'b1), "fall");
            wr(a + 8'h02, 8'h10);
            idle(3);
            pins(8'h01, c);
            wr(a, {4'ha, d[3:0]});
            idle(3);
            pins(8'h00, c);
            rd(a, ctl(1'b0, 1'b1, 1'b0), "clear");
            level[c] <= 1'b1;
            idle(10);
            wr(a, 8'h00);
            idle(3);
            pins(8'h00, c);
            level[c] <= 1'b0;
        end
        // Clock enable low must freeze the registers
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(8'h9d, 8'h31);
        ce <= 1'b1;
        rd(8'h9d, 8'h10, "frozen");
        tally_and_finish();
    end
endmodule : dcc_top_tb

// File: verilog/dcc_channel.sv
module dcc_channel
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic raw_in,
    input wire logic clr_rise,
    input wire logic clr_fall,
    output logic result,
    output logic rise_flag,
    output logic fall_flag
);
    // ==========================================
    // State
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic rise;
        logic fall;
    } dcc_chan_state_t;

    dcc_chan_state_t st;
    dcc_chan_state_t next_st;
    logic rise_evt;
    logic fall_evt;

    always_comb begin
        next_st = st;
        rise_evt = st.sync2 && !st.prev;
        fall_evt = !st.sync2 && st.prev;
        // Second stage only reads the first
        next_st.sync1 = raw_in;
        next_st.sync2 = st.sync1;  // [RQ21]
        next_st.prev = st.sync2;
        // Set beats a same-cycle software clear so no edge is lost
        if (rise_evt) begin
            next_st.rise = 1'b1;  // [RQ4]
        end else if (clr_rise) begin
            next_st.rise = 1'b0;  // [RQ5]
        end
        if (fall_evt) begin
            next_st.fall = 1'b1;  // [RQ3]
        end else if (clr_fall) begin
            next_st.fall = 1'b0;  // [RQ5]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign result = st.sync2;  // [RQ7]
    assign rise_flag = st.rise;
    assign fall_flag = st.fall;
endmodule : dcc_channel

// File: verilog/dcc_pkg.sv
package dcc_pkg;
    // ==========================================
    // Register addresses on the special function register bus
    localparam logic [7:0] DCC_ADDR_CMP1_CONTROL = 8'h9a;
    localparam logic [7:0] DCC_ADDR_CMP0_CONTROL = 8'h9b;
    localparam logic [7:0] DCC_ADDR_CMP1_MODE_SELECT = 8'h9c;
    localparam logic [7:0] DCC_ADDR_CMP0_MODE_SELECT = 8'h9d;
    localparam logic [7:0] DCC_ADDR_CMP1_INPUT_SELECT = 8'h9e;
    localparam logic [7:0] DCC_ADDR_CMP0_INPUT_SELECT = 8'h9f;

    // ==========================================
    // Field positions
    localparam int DCC_CN_ENABLE = 7;
    localparam int DCC_CN_RESULT = 6;
    localparam int DCC_CN_RISE = 5;
    localparam int DCC_CN_FALL = 4;
    localparam int DCC_CN_POS_HYST_LSB = 2;
    localparam int DCC_CN_NEG_HYST_LSB = 0;
    localparam int DCC_MD_RISE_IRQ_EN = 5;
    localparam int DCC_MD_FALL_IRQ_EN = 4;
    localparam int DCC_MD_SPEED_LSB = 0;
    localparam int DCC_MX_NEG_LSB = 4;
    localparam int DCC_MX_POS_LSB = 0;

    // ==========================================
    // Reset values
    localparam logic [7:0] DCC_RST_CONTROL = 8'h00;
    localparam logic [7:0] DCC_RST_MODE_SELECT = 8'h02;
    localparam logic [7:0] DCC_RST_INPUT_SELECT = 8'h00;
    localparam logic [1:0] DCC_RST_SPEED_MODE = 2'h2;

    // ==========================================
    // Per-comparator configuration handed to the analog macro
    typedef struct packed {
        logic enable;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
        logic [1:0] speed_mode;
        logic [1:0] pos_source;
        logic [1:0] neg_source;
    } dcc_analog_cfg_t;

    // Processor register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcc_sfr_req_t;
endpackage : dcc_pkg

// File: verilog/dcc_top.sv
// Overview of operation
// RQ1: A disabled comparator drives its port-pin outputs low.
// RQ2: Each comparator offers a raw output and a clock-synchronised output.
// RQ3: A falling comparator output sets the falling-edge flag.
// RQ4: A rising comparator output sets the rising-edge flag.
// RQ5: Edge flags stay set until software writes zero; hardware never clears.
// RQ6: Rising and falling edges can each raise the interrupt independently.
// RQ7: Read-only output-state bit returns the current comparator result.
// RQ8: Control bit 7 enables the comparator; zero disables and powers down.
// RQ9: Control bits 5 and 4 hold rising and falling flags, read/write.
// RQ10: Control bits 3-2 select positive hysteresis, 0/5/10/20 mV.
// RQ11: Control bits 1-0 select negative hysteresis, same four codes.
// RQ12: Mode bit 5 enables rising-edge interrupt.
// RQ13: Mode bit 4 enables falling-edge interrupt.
// RQ14: Mode bits 1-0 select response time; reset value is mode 2.
// RQ15: First comparator input-select bits 5-4 choose negative input pin.
// RQ16: First comparator input-select bits 1-0 choose positive input pin.
// RQ17: Second comparator input-select bits 5-4 choose negative input pin.
// RQ18: Second comparator input-select bits 1-0 choose positive input pin.
// RQ19: Unused mode and input-select bits read zero, writes ignored.
// RQ20: Second comparator control register matches the first in layout.
// RQ21: Raw output synchronised by two flops; irq is flag AND enable.
module dcc_top
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire dcc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic [1:0] cmp_analog_out,
    output dcc_analog_cfg_t [1:0] cmp_cfg,
    output logic [1:0] cmp_raw_pin,
    output logic [1:0] cmp_sync_pin,
    output logic [1:0] cmp_irq
);
    // ==========================================
    // Register state, index 0 and 1 per comparator
    typedef struct packed {
        logic [1:0] enable;
        logic [1:0][1:0] pos_hyst;
        logic [1:0][1:0] neg_hyst;
        logic [1:0] rise_irq_en;
        logic [1:0] fall_irq_en;
        logic [1:0][1:0] speed_mode;
        logic [1:0][1:0] pos_source;
        logic [1:0][1:0] neg_source;
        logic [1:0] sync_pin;
        logic [1:0] irq;
        logic [7:0] rdata;
    } dcc_state_t;

    dcc_state_t st;
    dcc_state_t next_st;
    logic [1:0] result;
    logic [1:0] rise_flag;
    logic [1:0] fall_flag;
    logic [1:0] clr_rise;
    logic [1:0] clr_fall;
    logic [1:0] raw_gated;

    // Decode used for both read and write paths: returns comparator index
    // and register kind (0 control, 1 mode, 2 input select, 3 none)
    function automatic logic [2:0] dcc_decode(input logic [7:0] a);
        if (a == DCC_ADDR_CMP0_CONTROL) begin
            return 3'h0;
        end else if (a == DCC_ADDR_CMP1_CONTROL) begin
            return 3'h4;
        end else if (a == DCC_ADDR_CMP0_MODE_SELECT) begin
            return 3'h1;
        end else if (a == DCC_ADDR_CMP1_MODE_SELECT) begin
            return 3'h5;
        end else if (a == DCC_ADDR_CMP0_INPUT_SELECT) begin
            return 3'h2;
        end else if (a == DCC_ADDR_CMP1_INPUT_SELECT) begin
            return 3'h6;
        end else begin
            return 3'h3;
        end
    endfunction : dcc_decode

    logic [2:0] dec;
    logic sel_idx;
    logic [1:0] sel_kind;
    assign dec = dcc_decode(sfr_req.addr);
    assign sel_idx = dec[2];
    assign sel_kind = dec[1:0];

    // ==========================================
    // Edge detection per comparator
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            // Raw path is purely combinational so it survives a stopped clock
            assign raw_gated[gi] = cmp_analog_out[gi] & st.enable[gi];  // [RQ1] [RQ2]
            assign clr_rise[gi] = ce && sfr_req.wr && sel_kind == 2'h0 && sel_idx == gi
                && !sfr_req.wdata[DCC_CN_RISE];  // [RQ5]
            assign clr_fall[gi] = ce && sfr_req.wr && sel_kind == 2'h0 && sel_idx == gi
                && !sfr_req.wdata[DCC_CN_FALL];  // [RQ5]
            dcc_channel u_chan (
                .clk_sys(clk_sys),
                .srst(srst),
                .ce(ce),
                .raw_in(raw_gated[gi]),
                .clr_rise(clr_rise[gi]),
                .clr_fall(clr_fall[gi]),
                .result(result[gi]),
                .rise_flag(rise_flag[gi]),
                .fall_flag(fall_flag[gi])
            );
            assign cmp_cfg[gi].enable = st.enable[gi];  // [RQ8]
            assign cmp_cfg[gi].pos_hyst = st.pos_hyst[gi];  // [RQ10]
            assign cmp_cfg[gi].neg_hyst = st.neg_hyst[gi];  // [RQ11]
            assign cmp_cfg[gi].speed_mode = st.speed_mode[gi];  // [RQ14]
            assign cmp_cfg[gi].pos_source = st.pos_source[gi];  // [RQ16] [RQ18]
            assign cmp_cfg[gi].neg_source = st.neg_source[gi];  // [RQ15] [RQ17]
        end
    endgenerate

    // ==========================================
    // Register writes, reads and output staging
    always_comb begin
        next_st = st;
        if (sfr_req.wr) begin
            case (sel_kind)
                2'h0: begin
                    // Same layout for both comparators; result bit is read-only
                    next_st.enable[sel_idx] = sfr_req.wdata[DCC_CN_ENABLE];  // [RQ8] [RQ20]
                    next_st.pos_hyst[sel_idx] =
                        sfr_req.wdata[DCC_CN_POS_HYST_LSB +: 2];  // [RQ10]
                    next_st.neg_hyst[sel_idx] =
                        sfr_req.wdata[DCC_CN_NEG_HYST_LSB +: 2];  // [RQ11]
                end
                2'h1: begin
                    next_st.rise_irq_en[sel_idx] = sfr_req.wdata[DCC_MD_RISE_IRQ_EN];  // [RQ12]
                    next_st.fall_irq_en[sel_idx] = sfr_req.wdata[DCC_MD_FALL_IRQ_EN];  // [RQ13]
                    next_st.speed_mode[sel_idx] = sfr_req.wdata[DCC_MD_SPEED_LSB +: 2];  // [RQ14]
                end
                2'h2: begin
                    next_st.neg_source[sel_idx] = sfr_req.wdata[DCC_MX_NEG_LSB +: 2];  // [RQ15] [RQ17]
                    next_st.pos_source[sel_idx] = sfr_req.wdata[DCC_MX_POS_LSB +: 2];  // [RQ16] [RQ18]
                end
                default: begin
                end
            endcase
        end
        next_st.rdata = 8'h00;
        if (sfr_req.rd) begin
            case (sel_kind)
                2'h0: begin
                    next_st.rdata[DCC_CN_ENABLE] = st.enable[sel_idx];
                    next_st.rdata[DCC_CN_RESULT] = result[sel_idx];  // [RQ7]
                    next_st.rdata[DCC_CN_RISE] = rise_flag[sel_idx];  // [RQ9]
                    next_st.rdata[DCC_CN_FALL] = fall_flag[sel_idx];  // [RQ9]
                    next_st.rdata[DCC_CN_POS_HYST_LSB +: 2] = st.pos_hyst[sel_idx];
                    next_st.rdata[DCC_CN_NEG_HYST_LSB +: 2] = st.neg_hyst[sel_idx];
                end
                2'h1: begin
                    // Unused bits stay zero
                    next_st.rdata[DCC_MD_RISE_IRQ_EN] = st.rise_irq_en[sel_idx];  // [RQ19]
                    next_st.rdata[DCC_MD_FALL_IRQ_EN] = st.fall_irq_en[sel_idx];
                    next_st.rdata[DCC_MD_SPEED_LSB +: 2] = st.speed_mode[sel_idx];
                end
                2'h2: begin
                    next_st.rdata[DCC_MX_NEG_LSB +: 2] = st.neg_source[sel_idx];  // [RQ19]
                    next_st.rdata[DCC_MX_POS_LSB +: 2] = st.pos_source[sel_idx];
                end
                default: begin
                end
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            // Level request; stays up until software clears the flag or its interrupt enable bit
            next_st.irq[i] = (rise_flag[i] && st.rise_irq_en[i])
                || (fall_flag[i] && st.fall_irq_en[i]);  // [RQ6] [RQ21]
            next_st.sync_pin[i] = result[i] && st.enable[i];  // [RQ1] [RQ2]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
            st.speed_mode <= {DCC_RST_SPEED_MODE, DCC_RST_SPEED_MODE};  // [RQ14]
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign cmp_sync_pin = st.sync_pin;
    assign cmp_irq = st.irq;
    // Raw output bypasses all flops by design: it must work with no clock
    assign cmp_raw_pin = raw_gated;  // [RQ2]
endmodule : dcc_top
